/* File: design/core_wait_exec.sv */
// Execution unit for pin waits, video wait, compare, launch and effect bits
//
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/1ps
module core_wait_exec (
  // Clock and reset
  input  wire logic                           clk_i,
  input  wire logic                           rst_i,
  // APB slave
  input  wire logic                           psel_i,
  input  wire logic                           penable_i,
  input  wire logic                           pwrite_i,
  input  wire logic [core_wait_pkg::APB_AW-1:0] paddr_i,
  input  wire logic [31:0]                    pwdata_i,
  output logic      [31:0]                    prdata_o,
  output logic                                pready_o,
  output logic                                pslverr_o,
  // Input pin ports
  input  wire logic [31:0]                    input_port_a_i,
  input  wire logic [31:0]                    input_port_b_i,
  // Video generator
  input  wire logic                           vid_ready_i,
  output logic                                vid_take_o,
  output logic      [31:0]                    vid_colors_o,
  output logic      [31:0]                    vid_pixels_o,
  // Core launch
  input  wire logic [2:0]                     launch_free_id_i,
  input  wire logic                           launch_none_i,
  output logic                                launch_start_o,
  output logic      [31:0]                    launch_value_o,
  // Status
  output logic                                busy_o,
  output logic                                zero_flag_o,
  output logic                                carry_flag_o
);
  import core_wait_pkg::*;

  exec_state_type state_r;
  exec_state_type state_nxt;

  logic [31:0] instr_r;
  logic [31:0] d_val_r;
  logic [31:0] s_val_r;
  logic [8:0]  reg_addr_r;
  logic        zero_r;
  logic        carry_r;
  logic        busy_r;
  logic        stall_r;
  logic [2:0]  launch_id_r;
  logic        launch_none_r;

  logic [31:0] pin_a_m_r;
  logic [31:0] pin_a_r;
  logic [31:0] pin_b_m_r;
  logic [31:0] pin_b_r;

  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  logic        apb_wait_r;
  logic        vid_take_r;
  logic [31:0] vid_colors_r;
  logic [31:0] vid_pixels_r;
  logic        launch_start_r;
  logic [31:0] launch_value_r;

  logic [5:0]  opc;
  logic        eff_z;
  logic        eff_c;
  logic        eff_r;
  logic        eff_i;
  logic [8:0]  dest_f;
  logic [8:0]  src_f;
  logic        idle;
  logic        access;
  logic        apb_wr;
  logic        issue;
  logic        flag_wr;
  logic [31:0] port_sel;
  logic [31:0] masked;
  logic        wake;
  logic [32:0] sum33;
  logic [31:0] result;
  logic        res_z;
  logic        res_c;
  logic [8:0]  mem_addr;
  logic        mem_we;
  logic [31:0] mem_wdata;
  logic [31:0] mem_rdata;

  // Decode
  assign opc    = instr_r[OPC_LSB +: 6];
  assign eff_z  = instr_r[EFF_Z_POS];
  assign eff_c  = instr_r[EFF_C_POS];
  assign eff_r  = instr_r[EFF_R_POS];
  assign eff_i  = instr_r[EFF_I_POS];
  assign dest_f = instr_r[DEST_LSB +: FLD_W];
  assign src_f  = instr_r[SRC_LSB +: FLD_W];
  assign idle   = (state_r == ST_IDLE);

  // APB decode; one access decoded once per transfer
  assign access  = psel_i & penable_i & ~pready_r & ~apb_wait_r;
  assign apb_wr  = access & pwrite_i;
  assign issue   = apb_wr & idle & (paddr_i == ADDR_INSTR);
  assign flag_wr = apb_wr & idle & (paddr_i == ADDR_FLAGS);

  // Pins come from outside the clock domain
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_a_m_r <= WORD_RST;
      pin_a_r   <= WORD_RST;
      pin_b_m_r <= WORD_RST;
      pin_b_r   <= WORD_RST;
    end else begin
      pin_a_m_r <= input_port_a_i;
      pin_a_r   <= pin_a_m_r;
      pin_b_m_r <= input_port_b_i;
      pin_b_r   <= pin_b_m_r;
    end
  end

  // Wake condition, evaluated every clock of the stall
  always_comb begin
    port_sel = (SINGLE_PORT || !carry_r) ? pin_a_r : pin_b_r;
    masked   = port_sel & s_val_r;
    case (opc)
      OPC_WAIT_PEQ: wake = (masked == d_val_r);
      OPC_WAIT_PNE: wake = (masked != d_val_r);
      OPC_WAIT_VID: wake = vid_ready_i;
      default:      wake = 1'b1;
    endcase
  end

  // Result and flag values
  always_comb begin
    sum33 = {1'b0, d_val_r} + {1'b0, s_val_r};
    case (opc)
      OPC_UCMP: begin
        result = d_val_r - s_val_r;
        res_z  = (d_val_r == s_val_r);
        res_c  = (d_val_r < s_val_r);
      end
      OPC_LAUNCH: begin
        result = {29'h0000_000, launch_id_r};
        res_z  = (launch_id_r == 3'h0);
        res_c  = launch_none_r;
      end
      default: begin
        // Sum taken as the zero test for video wait, not operand equality
        result = sum33[31:0];
        res_z  = (sum33[31:0] == 32'h0000_0000);
        res_c  = sum33[32];
      end
    endcase
  end

  // Sequencer; one memory port, so operands are read in turn
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:  if (issue) begin
        state_nxt = ST_RD_D;
      end
      ST_RD_D:  state_nxt = ST_RD_S;
      ST_RD_S:  state_nxt = ST_GET_S;
      ST_GET_S: state_nxt = ST_WAIT;
      ST_WAIT:  if (wake) begin
        state_nxt = ST_WB;
      end
      ST_WB:    state_nxt = ST_IDLE;
      default:  state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      busy_r  <= 1'b0;
      stall_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      busy_r  <= (state_nxt != ST_IDLE);
      stall_r <= (state_nxt == ST_WAIT);
    end
  end

  // Instruction and operands
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      instr_r <= INSTR_RST;
      d_val_r <= WORD_RST;
      s_val_r <= WORD_RST;
    end else begin
      if (issue) begin
        instr_r <= pwdata_i;
      end
      if (state_r == ST_RD_S) begin
        d_val_r <= mem_rdata;
      end
      if (state_r == ST_GET_S) begin
        s_val_r <= eff_i ? {23'h00_0000, src_f} : mem_rdata;
      end
    end
  end

  // Memory port arbitration: bus only while idle
  always_comb begin
    mem_addr  = reg_addr_r;
    mem_we    = 1'b0;
    mem_wdata = pwdata_i;
    case (state_r)
      ST_IDLE: begin
        mem_we = apb_wr & (paddr_i == ADDR_REG_DATA);
      end
      ST_RD_D:  mem_addr = dest_f;
      ST_RD_S:  mem_addr = src_f;
      ST_WB: begin
        mem_addr  = dest_f;
        mem_we    = eff_r;
        mem_wdata = result;
      end
      default: mem_addr = reg_addr_r;
    endcase
  end

  core_reg_mem u_mem (
    .clk_i   (clk_i),
    .addr_i  (mem_addr),
    .we_i    (mem_we),
    .wdata_i (mem_wdata),
    .rdata_o (mem_rdata)
  );

  // Flags; hardware and software writes never meet, software only while idle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      zero_r  <= 1'b0;
      carry_r <= 1'b0;
    end else if (state_r == ST_WB) begin
      if (eff_z) begin
        zero_r <= res_z;
      end
      if (eff_c) begin
        carry_r <= res_c;
      end
    end else if (flag_wr) begin
      zero_r  <= pwdata_i[FL_ZERO_POS];
      carry_r <= pwdata_i[FL_CARRY_POS];
    end
  end

  // Video hand-off, one pulse when the generator takes the words
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vid_take_r   <= 1'b0;
      vid_colors_r <= WORD_RST;
      vid_pixels_r <= WORD_RST;
    end else begin
      vid_take_r <= 1'b0;
      if (state_r == ST_WAIT && opc == OPC_WAIT_VID && vid_ready_i) begin
        vid_take_r   <= 1'b1;
        vid_colors_r <= d_val_r;
        vid_pixels_r <= s_val_r;
      end
    end
  end

  // Core launch; the free id is sampled in the same cycle as the start
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      launch_start_r <= 1'b0;
      launch_value_r <= WORD_RST;
      launch_id_r    <= 3'h0;
      launch_none_r  <= 1'b0;
    end else begin
      launch_start_r <= 1'b0;
      if (state_r == ST_WAIT && opc == OPC_LAUNCH) begin
        launch_start_r <= 1'b1;
        launch_value_r <= d_val_r;
        if (d_val_r[LAUNCH_NEXT_POS]) begin
          launch_id_r   <= launch_free_id_i;
          launch_none_r <= launch_none_i;
        end else begin
          launch_id_r   <= d_val_r[2:0];
          launch_none_r <= 1'b0;
        end
      end
    end
  end

  // Register address for the memory window
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reg_addr_r <= 9'h000;
    end else if (apb_wr && paddr_i == ADDR_REG_ADDR) begin
      reg_addr_r <= pwdata_i[8:0];
    end
  end

  // APB answer; memory window reads take one extra cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prdata_r   <= WORD_RST;
      pready_r   <= 1'b0;
      pslverr_r  <= 1'b0;
      apb_wait_r <= 1'b0;
    end else begin
      pready_r   <= 1'b0;
      pslverr_r  <= 1'b0;
      apb_wait_r <= 1'b0;
      if (apb_wait_r) begin
        prdata_r <= mem_rdata;
        pready_r <= 1'b1;
      end else if (access && pwrite_i) begin
        pready_r <= 1'b1;
        case (paddr_i)
          ADDR_INSTR:    pslverr_r <= ~idle;
          ADDR_FLAGS:    pslverr_r <= ~idle;
          ADDR_REG_ADDR: pslverr_r <= 1'b0;
          ADDR_REG_DATA: pslverr_r <= ~idle;
          default:       pslverr_r <= 1'b1;
        endcase
      end else if (access) begin
        pready_r <= 1'b1;
        prdata_r <= WORD_RST;
        case (paddr_i)
          ADDR_INSTR:    prdata_r <= instr_r;
          ADDR_STATUS: begin
            prdata_r[ST_BUSY_POS]  <= busy_r;
            prdata_r[ST_ZERO_POS]  <= zero_r;
            prdata_r[ST_CARRY_POS] <= carry_r;
            prdata_r[ST_STALL_POS] <= stall_r;
          end
          ADDR_FLAGS: begin
            prdata_r[FL_ZERO_POS]  <= zero_r;
            prdata_r[FL_CARRY_POS] <= carry_r;
          end
          ADDR_REG_ADDR: prdata_r[8:0] <= reg_addr_r;
          ADDR_REG_DATA: begin
            if (idle) begin
              pready_r   <= 1'b0;
              apb_wait_r <= 1'b1;
            end else begin
              pslverr_r <= 1'b1;
            end
          end
          default:       pslverr_r <= 1'b1;
        endcase
      end
    end
  end

  // Outputs
  assign prdata_o       = prdata_r;
  assign pready_o       = pready_r;
  assign pslverr_o      = pslverr_r;
  assign vid_take_o     = vid_take_r;
  assign vid_colors_o   = vid_colors_r;
  assign vid_pixels_o   = vid_pixels_r;
  assign launch_start_o = launch_start_r;
  assign launch_value_o = launch_value_r;
  assign busy_o         = busy_r;
  assign zero_flag_o    = zero_r;
  assign carry_flag_o   = carry_r;

endmodule // core_wait_exec

/* File: design/core_wait_pkg.sv */
// Constants for the wait and effect execution unit
package core_wait_pkg;

  // Register bus
  localparam int          APB_AW        = 12;
  localparam logic [11:0] ADDR_INSTR    = 12'h000;
  localparam logic [11:0] ADDR_STATUS   = 12'h004;
  localparam logic [11:0] ADDR_FLAGS    = 12'h008;
  localparam logic [11:0] ADDR_REG_ADDR = 12'h00c;
  localparam logic [11:0] ADDR_REG_DATA = 12'h010;

  // Instruction field positions
  localparam int OPC_LSB   = 26;
  localparam int EFF_Z_POS = 25;
  localparam int EFF_C_POS = 24;
  localparam int EFF_R_POS = 23;
  localparam int EFF_I_POS = 22;
  localparam int DEST_LSB  = 9;
  localparam int SRC_LSB   = 0;
  localparam int FLD_W     = 9;

  // Opcodes
  localparam logic [5:0] OPC_WAIT_PEQ  = 6'h3c;
  localparam logic [5:0] OPC_WAIT_PNE  = 6'h3d;
  localparam logic [5:0] OPC_WAIT_VID  = 6'h3f;
  localparam logic [5:0] OPC_UCMP      = 6'h21;
  localparam logic [5:0] OPC_LAUNCH    = 6'h03;

  // Status and flag register bits
  localparam int ST_BUSY_POS  = 0;
  localparam int ST_ZERO_POS  = 1;
  localparam int ST_CARRY_POS = 2;
  localparam int ST_STALL_POS = 3;
  localparam int FL_ZERO_POS  = 0;
  localparam int FL_CARRY_POS = 1;

  // Launch value bit asking for the next free core
  localparam int LAUNCH_NEXT_POS = 3;

  // Core options and reset values
  localparam logic        SINGLE_PORT  = 1'b0;
  localparam logic [31:0] INSTR_RST    = 32'h0000_0000;
  localparam logic [31:0] WORD_RST     = 32'h0000_0000;
  localparam int          MEM_DEPTH    = 512;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RD_D,
    ST_RD_S,
    ST_GET_S,
    ST_WAIT,
    ST_WB
  } exec_state_type;

endpackage

/* File: design/core_reg_mem.sv */
// Core register memory, one port, registered read data
`timescale 1ns/1ps
module core_reg_mem (
  // Clock
  input  wire logic        clk_i,
  // Port
  input  wire logic [8:0]  addr_i,
  input  wire logic        we_i,
  input  wire logic [31:0] wdata_i,
  output logic      [31:0] rdata_o
);
  import core_wait_pkg::*;

  logic [31:0] mem_r [MEM_DEPTH];

  // Read data lags the address by one edge
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_r[addr_i] <= wdata_i;
    end
    rdata_o <= mem_r[addr_i];
  end

endmodule // core_reg_mem

/* File: verif/core_wait_exec_checker.sv */
// Assertion checker for the wait and effect execution unit
`timescale 1ns/1ps
module core_wait_exec_checker (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Core
  input wire logic vid_ready_i,
  input wire logic vid_take_o,
  input wire logic launch_start_o,
  input wire logic busy_o,
  input wire logic zero_flag_o,
  input wire logic carry_flag_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_run5;
    busy_o [*5];
  endsequence
  sequence s_kept;
    $stable(zero_flag_o) && $stable(carry_flag_o);
  endsequence
  property p_ready_once;
    pready_o |=> !pready_o;
  endproperty
  property p_ready_cause;
    pready_o |-> $past(psel_i) && $past(penable_i);
  endproperty
  property p_err_ready;
    pslverr_o |-> pready_o;
  endproperty
  property p_min_run;
    $rose(busy_o) |-> s_run5;
  endproperty
  property p_take_cause;
    vid_take_o |-> $past(vid_ready_i) && $past(busy_o);
  endproperty
  property p_take_once;
    vid_take_o |=> !vid_take_o;
  endproperty
  property p_launch;
    launch_start_o |-> $past(busy_o) ##1 !launch_start_o;
  endproperty
  property p_flags_idle;
    !busy_o && !psel_i |=> s_kept;
  endproperty
  property p_flags_busy;
    busy_o ##1 busy_o |-> s_kept;
  endproperty
  a_ready_once: assert property (p_ready_once)
    else $error("pready longer than one cycle");
  a_ready_cause: assert property (p_ready_cause)
    else $error("pready without access");
  a_err_ready: assert property (p_err_ready)
    else $error("pslverr without pready");
  a_min_run: assert property (p_min_run)
    else $error("instruction shorter than five cycles");
  a_take_cause: assert property (p_take_cause)
    else $error("take without ready during wait");
  a_take_once: assert property (p_take_once)
    else $error("take longer than one cycle");
  a_launch: assert property (p_launch)
    else $error("launch pulse wrong");
  a_flags_idle: assert property (p_flags_idle)
    else $error("flags moved while idle");
  a_flags_busy: assert property (p_flags_busy)
    else $error("flags moved mid instruction");
endmodule // core_wait_exec_checker

bind core_wait_exec core_wait_exec_checker chk_u (.clk_i, .rst_i, .psel_i, .penable_i,
  .pready_o, .pslverr_o, .vid_ready_i, .vid_take_o, .launch_start_o, .busy_o,
  .zero_flag_o, .carry_flag_o);

/* File: verif/pin_video_model.sv */
// Pin ports and video generator facing the execution unit
`timescale 1ns/1ps
module pin_video_model (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Bench control
  input  wire logic        vid_on_i,
  input  wire logic [3:0]  vid_gap_i,
  input  wire logic [31:0] pins_a_i,
  input  wire logic [31:0] pins_b_i,
  // Toward the core
  input  wire logic        vid_take_i,
  output logic             vid_ready_o,
  output logic      [31:0] port_a_o,
  output logic      [31:0] port_b_o
);
  logic [3:0] gap_r;
  assign port_a_o = pins_a_i;
  assign port_b_o = pins_b_i;
  // Unstarted generator is never ready, so a wait hangs
  always_ff @(posedge clk_i) begin
    if (rst_i || !vid_on_i || vid_take_i) begin
      gap_r       <= 4'h0;
      vid_ready_o <= 1'b0;
    end else if (gap_r != vid_gap_i) begin
      gap_r <= gap_r + 4'h1;
    end else begin
      vid_ready_o <= 1'b1;
    end
  end
endmodule // pin_video_model

/* File: verif/core_wait_exec_tb.sv */
// Self-checking bench for the wait and effect execution unit
`timescale 1ns/1ps
module core_wait_exec_tb;
  import core_wait_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic        vid_on = 1'b0;
  logic [3:0]  vid_gap = 4'h0;
  logic [31:0] pins_a = 32'h0000_0000;
  logic [31:0] pins_b = 32'h0000_0000;
  logic [31:0] prdata_o, port_a, port_b, vid_colors_o, vid_pixels_o, launch_value_o, rd;
  logic        pready_o, pslverr_o, vid_ready_i, vid_take_o, launch_start_o, err;
  logic        busy_o, zero_flag_o, carry_flag_o;
  logic [32:0] sum;
  logic [31:0] vt [4] = '{32'hffff_fffd, 32'hffff_fffe, 32'hffff_ffff, 32'h0000_0000};
  int          err_count = 0;
  int          checks = 0;
  int          cyc = 0;
  int          starts = 0;
  int          takes = 0;

  core_wait_exec dut_u (.clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .input_port_a_i(port_a),
    .input_port_b_i(port_b), .vid_ready_i, .vid_take_o, .vid_colors_o, .vid_pixels_o,
    .launch_free_id_i(3'h5), .launch_none_i(1'b0), .launch_start_o, .launch_value_o,
    .busy_o, .zero_flag_o, .carry_flag_o);
  pin_video_model peer_u (.clk_i, .rst_i, .vid_on_i(vid_on), .vid_gap_i(vid_gap),
    .pins_a_i(pins_a), .pins_b_i(pins_b), .vid_take_i(vid_take_o),
    .vid_ready_o(vid_ready_i), .port_a_o(port_a), .port_b_o(port_b));

  always #25 clk_i = ~clk_i;

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (launch_start_o === 1'b1) starts <= starts + 1;
    if (vid_take_o === 1'b1) takes <= takes + 1;
    if (cyc == 20000) begin
      err_count++;
      $display("[FAIL] cycles expected below 20000 seen %0d", cyc);
      tally_and_finish();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    chk("pready", 32'h1, {31'h0, pready_o});
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wreg(input logic [8:0] a, input logic [31:0] v);
    apb(1'b1, ADDR_REG_ADDR, {23'h0, a});
    apb(1'b1, ADDR_REG_DATA, v);
  endtask

  task automatic rreg(input logic [8:0] a);
    apb(1'b1, ADDR_REG_ADDR, {23'h0, a});
    apb(1'b0, ADDR_REG_DATA, 32'h0);
  endtask

  task automatic issue(input logic [5:0] op, input logic [3:0] eff, input logic [8:0] d, s);
    apb(1'b1, ADDR_INSTR, {op, eff, 4'hf, d, s});
  endtask

  task automatic finish_op;
    int n;
    n = 0;
    do begin
      apb(1'b0, ADDR_STATUS, 32'h0);
      n++;
    end while (rd[ST_BUSY_POS] !== 1'b0 && n < 60);
    chk("idle", 32'h0, {31'h0, rd[ST_BUSY_POS]});
  endtask

  task automatic exec(input logic [5:0] op, input logic [3:0] eff, input logic [8:0] d, s);
    issue(op, eff, d, s);
    finish_op;
  endtask

  // Selected port blocks, the other already wakes: a wrong port choice ends early
  task automatic pin_wait(input logic [5:0] op, input logic c, input logic [31:0] blk, wak);
    apb(1'b1, ADDR_FLAGS, {30'h0, c, 1'b0});
    pins_a <= c ? wak : blk;
    pins_b <= c ? blk : wak;
    issue(op, 4'h1, 9'h003, 9'h0ff);
    repeat (12) @(posedge clk_i);
    chk("stalled", 32'h1, {31'h0, busy_o});
    if (c) pins_b <= wak;
    else pins_a <= wak;
    finish_op;
    rreg(9'h003);
    chk("pin dest", 32'h0000_00a5, rd);
  endtask

  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status", 32'h0, rd);
    apb(1'b0, 12'h100, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    wreg(9'h001, 32'h0000_0002);
    issue(OPC_WAIT_VID, 4'h0, 9'h001, 9'h001);
    repeat (20) @(posedge clk_i);
    chk("vid stall", 32'h1, {31'h0, busy_o});
    // Busy and stalled bits both up, flags still clear from reset
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("stall status", 32'h9, rd);
    apb(1'b1, ADDR_INSTR, 32'h0);
    chk("refused", 32'h1, {31'h0, err});
    vid_on <= 1'b1;
    finish_op;
    chk("takes", 32'h1, takes);
    for (int i = 0; i < 4; i++) begin
      vid_gap <= 4'(i * 5);
      wreg(9'h001, 32'h0000_0002);
      wreg(9'h002, vt[i]);
      sum = 33'h0_0000_0002 + {1'b0, vt[i]};
      exec(OPC_WAIT_VID, 4'he, 9'h001, 9'h002);
      chk("colors", 32'h2, vid_colors_o);
      chk("pixels", vt[i], vid_pixels_o);
      chk("vid zero", {31'h0, sum[31:0] == 32'h0}, {31'h0, zero_flag_o});
      chk("vid carry", {31'h0, sum[32]}, {31'h0, carry_flag_o});
      rreg(9'h001);
      chk("vid dest", sum[31:0], rd);
    end
    apb(1'b1, ADDR_FLAGS, 32'h0000_0003);
    exec(OPC_WAIT_VID, 4'h1, 9'h001, 9'h1a5);
    chk("imm pixels", 32'h0000_01a5, vid_pixels_o);
    // One take per video wait, never a repeat
    chk("all takes", 32'h6, takes);
    chk("flags kept", 32'h3, {30'h0, carry_flag_o, zero_flag_o});
    rreg(9'h001);
    chk("dest kept", 32'h2, rd);
    wreg(9'h003, 32'h0000_00a5);
    pin_wait(OPC_WAIT_PEQ, 1'b0, 32'h1234_5600, 32'hffff_ffa5);
    pin_wait(OPC_WAIT_PEQ, 1'b1, 32'h1234_5600, 32'hffff_ffa5);
    pin_wait(OPC_WAIT_PNE, 1'b0, 32'h0000_00a5, 32'h0000_0000);
    pin_wait(OPC_WAIT_PNE, 1'b1, 32'h0000_00a5, 32'h0000_0000);
    wreg(9'h004, 32'h0000_0005);
    wreg(9'h005, 32'h0000_0009);
    // Carry left set by the last pin wait would hide a missing update
    apb(1'b1, ADDR_FLAGS, 32'h0000_0000);
    exec(OPC_UCMP, 4'h4, 9'h004, 9'h005);
    chk("cmp below", 32'h1, {31'h0, carry_flag_o});
    exec(OPC_UCMP, 4'h4, 9'h005, 9'h004);
    chk("cmp above", 32'h0, {31'h0, carry_flag_o});
    exec(OPC_UCMP, 4'h8, 9'h004, 9'h004);
    chk("cmp equal", 32'h1, {31'h0, zero_flag_o});
    exec(OPC_UCMP, 4'h0, 9'h004, 9'h005);
    chk("carry kept", 32'h0, {31'h0, carry_flag_o});
    chk("zero kept", 32'h1, {31'h0, zero_flag_o});
    wreg(9'h006, 32'h0000_0008);
    exec(OPC_LAUNCH, 4'h2, 9'h006, 9'h000);
    chk("launches", 32'h1, starts);
    chk("launch value", 32'h8, launch_value_o);
    rreg(9'h006);
    chk("launch id", 32'h5, rd);
    tally_and_finish();
  end
endmodule // core_wait_exec_tb
